/* pkg/dec_map.svh */
// Register offsets, field layout, reset values and timing for the counter timer
`ifndef DEC_MAP_SVH
`define DEC_MAP_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define DEC_OFS_SELECT 6'h00
`define DEC_OFS_INC_SRC 6'h04
`define DEC_OFS_INC_ACT 6'h08
`define DEC_OFS_DELAY 6'h0c
`define DEC_OFS_DURATION 6'h10
`define DEC_OFS_TRG_SRC 6'h14
`define DEC_OFS_TRG_ACT 6'h18
`define DEC_OFS_RST_SRC 6'h1c
`define DEC_OFS_RST_ACT 6'h20
`define DEC_OFS_COUNT 6'h24
`define DEC_OFS_CAPTURED 6'h28
`define DEC_OFS_STATE 6'h2c
// ****************************************
// Field positions and reset values
// ****************************************
`define DEC_SEL_BIT 0
`define DEC_SRC_MSB 4
`define DEC_ACT_MSB 2
`define DEC_SRC_OFF 5'h00
`define DEC_ACT_RST 3'h3
`define DEC_CNT_RST 32'h0000_0000
`define DEC_CNT_MAX 32'hffff_ffff
// Sources that are already one-cycle events
`define DEC_PULSE_MASK 32'h0003_3c02
// ****************************************
// Timing
// ****************************************
`define DEC_TICK_NS 1000
`define DEC_CLK_NS 40
`define DEC_TICK_CYC (`DEC_TICK_NS / `DEC_CLK_NS)
`endif

/* pkg/dec_pkg.sv */
// Types and the event qualifier shared by the counter timer modules
package dec_pkg;
   // Activation codes in register order
   typedef enum logic [2:0] {
      act_level_low, act_level_high, act_falling, act_rising, act_any
   } dec_act_type;
   // Unit states in status register order
   typedef enum logic [2:0] {
      state_idle, state_awaiting_trigger, state_running, state_done, state_wrapped
   } dec_state_type;
   // Whole state of one counter unit
   typedef struct packed {
      dec_state_type state;
      logic [31:0] count;
      logic [31:0] captured;
      logic start_ev;
      logic end_ev;
      logic prev_inc;
      logic prev_trg;
      logic prev_rst;
   } dec_unit_type;
   // Whole state of the top level
   typedef struct packed {
      logic sel;
      logic waitreq;
      logic [31:0] rdata;
      logic [1:0][4:0] inc_src;
      logic [1:0][2:0] inc_act;
      logic [1:0][31:0] delay;
      logic [1:0][31:0] duration;
      logic [1:0][4:0] trg_src;
      logic [1:0][2:0] trg_act;
      logic [1:0][4:0] rst_src;
      logic [1:0][2:0] rst_act;
      logic [3:0] line_s1;
      logic [3:0] line_s2;
      logic [4:0] tick_cnt;
      logic tick;
   } dec_top_type;
   // Turns a raw source into a hit: a pulse source as it is, any other by its activation
   function automatic logic dec_qualify(input logic [2:0] act, input logic cur,
                                        input logic prev, input logic pulse);
      logic hit;
      hit = 1'b0;
      if (pulse) begin
         hit = cur;
      end else begin
         case (dec_act_type'(act))
            act_level_low: hit = !cur;
            act_level_high: hit = cur;
            act_falling: hit = prev && !cur;
            act_rising: hit = !prev && cur;
            act_any: hit = prev != cur;
            default: hit = 1'b0;
         endcase
      end
      return hit;
   endfunction
endpackage

/* tb/dec_far_model.sv */
// Far side model: camera lines and exposure logic feeding the counter timer
`timescale 1ns/1ps
module dec_far_model (
   input wire logic mclk_in, // System clock
   input wire logic lvl_in, // Requested line level
   input wire logic tog_in, // Each change asks for one exposure pulse
   output logic [3:0] line_out, // Camera lines
   output logic exp_start_out, // Exposure start pulse
   output logic exp_end_out, // Exposure end pulse
   output logic ftw_out // Waiting for frame trigger level
);
   logic tog_q = 1'b0;
   initial begin
      line_out = 4'h0;
      exp_start_out = 1'b0;
      exp_end_out = 1'b0;
      ftw_out = 1'b0;
   end
   // Exposure end trails start by one cycle, lines follow the request
   always @(posedge mclk_in) begin
      tog_q <= tog_in;
      exp_start_out <= tog_in ^ tog_q;
      exp_end_out <= exp_start_out;
      line_out <= {4{lvl_in}};
      ftw_out <= lvl_in;
   end
endmodule // dec_far_model

/* tb/dec_top_bench.sv */
// Self-checking testbench for the dual event counter timer
`timescale 1ns/1ps
module dec_top_bench;
   logic mclk_in = 1'b0, rst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
   logic lvl = 1'b0, tog = 1'b0, avs_waitrequest_out, es_w, ee_w, ftw_w;
   logic [5:0] avs_address_in = 6'h00;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
   logic [3:0] user_output_in = 4'h0, line_w;
   logic [1:0] start_w, end_w;
   int n_mismatch = 0, n_tests = 0, n_start0 = 0, n_end0 = 0, n_start1 = 0, n_end1 = 0;
   logic [4:0] src_t [3] = '{5'h02, 5'h06, 5'h06};
   logic [2:0] act_t [3] = '{3'h3, 3'h2, 3'h4};
   logic [31:0] exp_t [3] = '{32'h2, 32'h2, 32'h4};
   dec_top dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .line_in(line_w), .user_output_in(user_output_in),
      .logic_block_in(2'h0), .exposure_start_in(es_w), .exposure_end_in(ee_w),
      .frame_trigger_waiting_in(ftw_w), .unit_start_event_out(start_w), .unit_end_event_out(end_w));
   dec_far_model far_u (.mclk_in(mclk_in), .lvl_in(lvl), .tog_in(tog), .line_out(line_w),
      .exp_start_out(es_w), .exp_end_out(ee_w), .ftw_out(ftw_w));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, want);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk_in);
   endtask
   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= w;
      avs_read_in <= !w;
      @(posedge mclk_in);
      // Only the watchdog ends a wait that never sees waitrequest low
      while (avs_waitrequest_out !== 1'b0) begin
         @(posedge mclk_in);
      end
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge mclk_in);
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] want);
      bus(1'b0, a, 32'h0);
      chk(q, want);
   endtask
   // Exposure pulses, spaced apart
   task automatic pls(input int k);
      repeat (k) begin
         tog <= !tog;
         cyc(4);
      end
   endtask
   // One high then low period on line and user output 0
   task automatic tgl;
      lvl <= 1'b1;
      user_output_in <= 4'h1;
      cyc(4);
      lvl <= 1'b0;
      user_output_in <= 4'h0;
      cyc(4);
   endtask
   // ****************************************
   // Clock, event counting, watchdog
   // ****************************************
   initial begin
      forever #20 mclk_in = !mclk_in;
   end
   always @(posedge mclk_in) begin
      if (start_w[0] === 1'b1) n_start0++;
      if (end_w[0] === 1'b1) n_end0++;
      if (start_w[1] === 1'b1) n_start1++;
      if (end_w[1] === 1'b1) n_end1++;
   end
   initial begin
      cyc(5000);
      n_mismatch++;
      end_of_test;
   end
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      cyc(12);
      rst_in <= 1'b0;
      cyc(1);
      rd(6'h08, 32'h3);
      rd(6'h2c, 32'h0);
      rd(6'h30, 32'h0);
      wr(6'h00, 32'h1);
      wr(6'h04, 32'hc);
      wr(6'h0c, 32'h1);
      wr(6'h10, 32'h1);
      wr(6'h00, 32'h0);
      wr(6'h0c, 32'h2);
      wr(6'h10, 32'h3);
      wr(6'h04, 32'h10);
      pls(3);
      rd(6'h24, 32'h3);
      rd(6'h2c, 32'h3);
      chk(32'(n_start0), 32'h1);
      chk(32'(n_end0), 32'h1);
      chk(32'(n_start1), 32'h1);
      chk(32'(n_end1), 32'h1);
      wr(6'h24, 32'h55);
      rd(6'h24, 32'h3);
      wr(6'h00, 32'h1);
      rd(6'h0c, 32'h1);
      rd(6'h24, 32'h1);
      wr(6'h00, 32'h0);
      wr(6'h10, 32'h0);
      // Edge activations on a line and on a user output
      for (int i = 0; i < 3; i++) begin
         wr(6'h04, 32'h0);
         wr(6'h08, 32'(act_t[i]));
         wr(6'h04, 32'(src_t[i]));
         tgl;
         tgl;
         rd(6'h24, exp_t[i]);
      end
      // Start trigger, then stop reset with capture
      wr(6'h04, 32'h0);
      wr(6'h14, 32'h7);
      wr(6'h04, 32'h10);
      rd(6'h2c, 32'h1);
      pls(1);
      rd(6'h24, 32'h0);
      user_output_in <= 4'h2;
      cyc(2);
      rd(6'h2c, 32'h2);
      pls(2);
      rd(6'h24, 32'h2);
      wr(6'h1c, 32'h8);
      rd(6'h14, 32'h0);
      user_output_in <= 4'h6;
      cyc(2);
      rd(6'h28, 32'h2);
      rd(6'h24, 32'h0);
      end_of_test;
   end
endmodule // dec_top_bench

/* verilog/dec_top.sv */
// Dual event counter timer with Avalon-MM register access
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "dec_map.svh"
// How it works
// - Two units, chosen by a select bit
// - Increment on a selectable event source
// - Qualify increment by its activation mode
// - Start event when count reaches delay
// - End event when count reaches duration
// - Trigger and reset source mutually exclusive
// - Unit starts counting on trigger source
// - Qualify trigger by its activation mode
// - Reset source clears count, restarting a done or wrapped unit
// - Qualify reset by its activation mode
// - Live count of selected unit readable
// - Count captured on unit reset
// - State of selected unit readable
// - States idle, awaiting, running, done, wrapped
module dec_top (
   input wire logic mclk_in, // System clock, 25 MHz
   input wire logic rst_in, // Synchronous reset, active high
   input wire logic [5:0] avs_address_in, // Byte address
   input wire logic avs_read_in, // Read request
   input wire logic avs_write_in, // Write request
   input wire logic [31:0] avs_writedata_in, // Write data
   input wire logic [3:0] avs_byteenable_in, // Byte lanes
   output logic [31:0] avs_readdata_out, // Read data
   output logic avs_waitrequest_out, // Stall until answer
   input wire logic [3:0] line_in, // Camera I/O lines, asynchronous
   input wire logic [3:0] user_output_in, // User output levels
   input wire logic [1:0] logic_block_in, // Logic block outputs
   input wire logic exposure_start_in, // Exposure start pulse
   input wire logic exposure_end_in, // Exposure end pulse
   input wire logic frame_trigger_waiting_in, // Waiting for frame trigger
   output logic [1:0] unit_start_event_out, // Start event pulses
   output logic [1:0] unit_end_event_out // End event pulses
);
   // ****************************************
   // State and internal signals
   // ****************************************
   dec_pkg::dec_top_type st, next_st;
   logic [31:0] src_vec;
   logic [1:0][31:0] cnt;
   logic [1:0][31:0] cap;
   logic [1:0][2:0] ust;
   logic [1:0] sev;
   logic [1:0] eev;
   logic req;
   logic take_wr;
   logic [31:0] wmerged;
   logic [31:0] rd;

   // Byte lane merge of write data into an old value
   function automatic logic [31:0] dec_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // ****************************************
   // Source vector
   // ****************************************
   // Code order: off, tick, lines, user, starts, ends, blocks, exposure, wait
   assign src_vec = {13'h0000,
                     frame_trigger_waiting_in,
                     exposure_end_in,
                     exposure_start_in,
                     logic_block_in,
                     eev[1],
                     eev[0],
                     sev[1],
                     sev[0],
                     user_output_in,
                     st.line_s2,
                     st.tick,
                     1'b0};

   // ****************************************
   // Counter units
   // ****************************************
   // One unit per counter, both fed from the shared vector
   for (genvar u = 0; u < 2; u++) begin : g_unit
      dec_unit u_unit (
         .mclk_in(mclk_in),
         .rst_in(rst_in),
         .src_vec_in(src_vec),
         .inc_src_in(st.inc_src[u]),
         .inc_act_in(st.inc_act[u]),
         .trg_src_in(st.trg_src[u]),
         .trg_act_in(st.trg_act[u]),
         .rst_src_in(st.rst_src[u]),
         .rst_act_in(st.rst_act[u]),
         .delay_in(st.delay[u]),
         .duration_in(st.duration[u]),
         .count_out(cnt[u]),
         .captured_out(cap[u]),
         .state_out(ust[u]),
         .start_out(sev[u]),
         .end_out(eev[u])
      );
   end

   assign unit_start_event_out = sev;
   assign unit_end_event_out = eev;

   // ****************************************
   // Register bus
   // ****************************************
   // A write lands at the edge where waitrequest is seen low
   assign req = avs_read_in || avs_write_in;
   assign take_wr = avs_write_in && !st.waitreq;

   // Merged write value over the addressed register
   always_comb begin
      wmerged = 32'h0;
      case (avs_address_in)
         `DEC_OFS_SELECT: wmerged = dec_merge({31'h0, st.sel}, avs_writedata_in,
                                              avs_byteenable_in);
         `DEC_OFS_INC_SRC: wmerged = dec_merge({27'h0, st.inc_src[st.sel]},
                                               avs_writedata_in, avs_byteenable_in);
         `DEC_OFS_INC_ACT: wmerged = dec_merge({29'h0, st.inc_act[st.sel]},
                                               avs_writedata_in, avs_byteenable_in);
         `DEC_OFS_DELAY: wmerged = dec_merge(st.delay[st.sel], avs_writedata_in,
                                             avs_byteenable_in);
         `DEC_OFS_DURATION: wmerged = dec_merge(st.duration[st.sel], avs_writedata_in,
                                                avs_byteenable_in);
         `DEC_OFS_TRG_SRC: wmerged = dec_merge({27'h0, st.trg_src[st.sel]},
                                               avs_writedata_in, avs_byteenable_in);
         `DEC_OFS_TRG_ACT: wmerged = dec_merge({29'h0, st.trg_act[st.sel]},
                                               avs_writedata_in, avs_byteenable_in);
         `DEC_OFS_RST_SRC: wmerged = dec_merge({27'h0, st.rst_src[st.sel]},
                                               avs_writedata_in, avs_byteenable_in);
         `DEC_OFS_RST_ACT: wmerged = dec_merge({29'h0, st.rst_act[st.sel]},
                                               avs_writedata_in, avs_byteenable_in);
         default: wmerged = 32'h0;
      endcase
   end

   // Read mux; unmapped offsets read as zero
   always_comb begin
      rd = 32'h0;
      case (avs_address_in)
         `DEC_OFS_SELECT: rd = {31'h0, st.sel};
         `DEC_OFS_INC_SRC: rd = {27'h0, st.inc_src[st.sel]};
         `DEC_OFS_INC_ACT: rd = {29'h0, st.inc_act[st.sel]};
         `DEC_OFS_DELAY: rd = st.delay[st.sel];
         `DEC_OFS_DURATION: rd = st.duration[st.sel];
         `DEC_OFS_TRG_SRC: rd = {27'h0, st.trg_src[st.sel]};
         `DEC_OFS_TRG_ACT: rd = {29'h0, st.trg_act[st.sel]};
         `DEC_OFS_RST_SRC: rd = {27'h0, st.rst_src[st.sel]};
         `DEC_OFS_RST_ACT: rd = {29'h0, st.rst_act[st.sel]};
         `DEC_OFS_COUNT: rd = cnt[st.sel];
         `DEC_OFS_CAPTURED: rd = cap[st.sel];
         `DEC_OFS_STATE: rd = {29'h0, ust[st.sel]};
         default: rd = 32'h0;
      endcase
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_st = st;
      // Two-flop synchroniser for the camera lines
      next_st.line_s1 = line_in;
      next_st.line_s2 = st.line_s1;
      // Microsecond tick from the system clock
      next_st.tick = 1'b0;
      if (st.tick_cnt == 5'(`DEC_TICK_CYC - 1)) begin
         next_st.tick_cnt = 5'h00;
         next_st.tick = 1'b1;
      end else begin
         next_st.tick_cnt = st.tick_cnt + 5'h01;
      end
      // Bus handshake: one stall cycle, then the answer
      if (req && st.waitreq) begin
         next_st.waitreq = 1'b0;
         next_st.rdata = rd;
      end else begin
         next_st.waitreq = 1'b1;
      end
      // Register writes: the unit select, or a field of the selected unit
      if (take_wr) begin
         case (avs_address_in)
            `DEC_OFS_SELECT: next_st.sel = wmerged[`DEC_SEL_BIT];
            `DEC_OFS_INC_SRC: next_st.inc_src[st.sel] = wmerged[`DEC_SRC_MSB:0];
            `DEC_OFS_INC_ACT: next_st.inc_act[st.sel] = wmerged[`DEC_ACT_MSB:0];
            `DEC_OFS_DELAY: next_st.delay[st.sel] = wmerged;
            `DEC_OFS_DURATION: next_st.duration[st.sel] = wmerged;
            `DEC_OFS_TRG_SRC: begin
               next_st.trg_src[st.sel] = wmerged[`DEC_SRC_MSB:0];
               if (wmerged[`DEC_SRC_MSB:0] != `DEC_SRC_OFF) begin
                  next_st.rst_src[st.sel] = `DEC_SRC_OFF;
               end
            end
            `DEC_OFS_TRG_ACT: next_st.trg_act[st.sel] = wmerged[`DEC_ACT_MSB:0];
            `DEC_OFS_RST_SRC: begin
               next_st.rst_src[st.sel] = wmerged[`DEC_SRC_MSB:0];
               if (wmerged[`DEC_SRC_MSB:0] != `DEC_SRC_OFF) begin
                  next_st.trg_src[st.sel] = `DEC_SRC_OFF;
               end
            end
            `DEC_OFS_RST_ACT: next_st.rst_act[st.sel] = wmerged[`DEC_ACT_MSB:0];
            default: next_st.sel = st.sel;
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         st <= '0;
         st.waitreq <= 1'b1;
         st.inc_act <= {2{`DEC_ACT_RST}};
         st.trg_act <= {2{`DEC_ACT_RST}};
         st.rst_act <= {2{`DEC_ACT_RST}};
      end else begin
         st <= next_st;
      end
   end

   assign avs_readdata_out = st.rdata;
   assign avs_waitrequest_out = st.waitreq;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   a_bus_answer: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("no answer one cycle after request");
   a_bus_release: assert property (req && !avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest not raised after answer");
   a_sources_exclusive: assert property (
      !(st.trg_src[0] != 5'h00 && st.rst_src[0] != 5'h00) &&
      !(st.trg_src[1] != 5'h00 && st.rst_src[1] != 5'h00))
      else $error("trigger and reset both active");
   a_trg_clears_rst: assert property (take_wr && avs_address_in == `DEC_OFS_TRG_SRC
      && avs_byteenable_in[0] && avs_writedata_in[4:0] != 5'h00
      |=> st.rst_src[$past(st.sel)] == 5'h00)
      else $error("trigger write left reset source on");
   a_select_write: assert property (take_wr && avs_address_in == `DEC_OFS_SELECT
      && avs_byteenable_in[0] |=> st.sel == $past(avs_writedata_in[0]))
      else $error("unit select not written");
   a_count_read: assert property (avs_read_in && avs_waitrequest_out
      && avs_address_in == `DEC_OFS_COUNT
      |=> !avs_waitrequest_out && avs_readdata_out == $past(cnt[st.sel]))
      else $error("live count read mismatch");
   a_state_read: assert property (avs_read_in && avs_waitrequest_out
      && avs_address_in == `DEC_OFS_STATE
      |=> avs_readdata_out == {29'h0, $past(ust[st.sel])})
      else $error("unit state read mismatch");
   a_tick_period: assert property (st.tick |-> ##25 st.tick)
      else $error("microsecond tick period wrong");

   c_bus_write: cover property (take_wr ##1 avs_read_in);
   c_chain: cover property (sev[0] ##[1:200] sev[1]);
endmodule // dec_top

/* verilog/dec_unit.sv */
// One counter timer unit: qualification, counting, start and end events
`timescale 1ns/1ps
`include "dec_map.svh"
module dec_unit (
   input wire logic mclk_in, // System clock
   input wire logic rst_in, // Synchronous reset, active high
   input wire logic [31:0] src_vec_in, // All selectable sources
   input wire logic [4:0] inc_src_in, // Increment source code
   input wire logic [2:0] inc_act_in, // Increment activation
   input wire logic [4:0] trg_src_in, // Start trigger source code
   input wire logic [2:0] trg_act_in, // Start trigger activation
   input wire logic [4:0] rst_src_in, // Stop reset source code
   input wire logic [2:0] rst_act_in, // Stop reset activation
   input wire logic [31:0] delay_in, // Start delay count
   input wire logic [31:0] duration_in, // End duration count
   output logic [31:0] count_out, // Live count
   output logic [31:0] captured_out, // Count captured at reset
   output logic [2:0] state_out, // Unit state
   output logic start_out, // Start event pulse
   output logic end_out // End event pulse
);
   dec_pkg::dec_unit_type st, next_st;
   logic inc_on, trg_on, rst_on, inc_hit, trg_hit, rst_hit;
   logic [31:0] pmask;

   // Qualified hits of the three selected sources
   assign pmask = `DEC_PULSE_MASK;
   assign inc_on = inc_src_in != `DEC_SRC_OFF;
   assign trg_on = trg_src_in != `DEC_SRC_OFF;
   assign rst_on = rst_src_in != `DEC_SRC_OFF;
   assign inc_hit = inc_on && dec_pkg::dec_qualify(inc_act_in, src_vec_in[inc_src_in],
      st.prev_inc, pmask[inc_src_in]);
   assign trg_hit = trg_on && dec_pkg::dec_qualify(trg_act_in, src_vec_in[trg_src_in],
      st.prev_trg, pmask[trg_src_in]);
   assign rst_hit = rst_on && dec_pkg::dec_qualify(rst_act_in, src_vec_in[rst_src_in],
      st.prev_rst, pmask[rst_src_in]);

   // Next state of the unit
   always_comb begin
      next_st = st;
      next_st.start_ev = 1'b0;
      next_st.end_ev = 1'b0;
      next_st.prev_inc = src_vec_in[inc_src_in];
      next_st.prev_trg = src_vec_in[trg_src_in];
      next_st.prev_rst = src_vec_in[rst_src_in];
      if (!inc_on) begin
         next_st.state = dec_pkg::state_idle;
      end else begin
         case (st.state)
            dec_pkg::state_idle: begin
               next_st.count = `DEC_CNT_RST;
               next_st.state = trg_on ? dec_pkg::state_awaiting_trigger
                                      : dec_pkg::state_running;
            end
            dec_pkg::state_awaiting_trigger: begin
               if (trg_hit) begin
                  next_st.state = dec_pkg::state_running;
               end
            end
            dec_pkg::state_running: begin
               if (rst_hit) begin
                  next_st.captured = st.count;
                  next_st.count = `DEC_CNT_RST;
               end else if (inc_hit) begin
                  next_st.count = st.count + 32'h1;
                  if (st.count == `DEC_CNT_MAX) begin
                     next_st.state = dec_pkg::state_wrapped;
                  end
                  if (st.count + 32'h1 == delay_in) begin
                     next_st.start_ev = 1'b1;
                  end
                  if (st.count + 32'h1 == duration_in) begin
                     next_st.end_ev = 1'b1;
                     next_st.state = dec_pkg::state_done;
                  end
               end
            end
            dec_pkg::state_done, dec_pkg::state_wrapped: begin
               if (rst_hit) begin
                  next_st.captured = st.count;
                  next_st.count = `DEC_CNT_RST;
                  next_st.state = dec_pkg::state_running;
               end else if (trg_hit) begin
                  next_st.count = `DEC_CNT_RST;
                  next_st.state = dec_pkg::state_running;
               end
            end
            default: next_st.state = dec_pkg::state_idle;
         endcase
      end
   end

   // State register
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign count_out = st.count;
   assign captured_out = st.captured;
   assign state_out = st.state;
   assign start_out = st.start_ev;
   assign end_out = st.end_ev;

   // Checks of the unit behaviour
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   a_start_at_delay: assert property (start_out |-> count_out == delay_in)
      else $error("start event away from delay");
   a_end_done: assert property (end_out |-> state_out == 3'h3 && count_out == duration_in)
      else $error("end event without done state");
   a_capture_reset: assert property (inc_on && st.state == dec_pkg::state_running && rst_hit
      |=> captured_out == $past(count_out) && count_out == 32'h0)
      else $error("count not captured on reset");
   a_trigger_start: assert property (inc_on && st.state == dec_pkg::state_awaiting_trigger
      && trg_hit |=> state_out == 3'h2)
      else $error("trigger did not start unit");
   a_count_step: assert property (inc_on && st.state == dec_pkg::state_running && inc_hit
      && !rst_hit |=> count_out == $past(count_out) + 32'h1)
      else $error("count did not step");
   c_start: cover property (start_out);
   c_done: cover property (end_out ##[1:50] state_out == 3'h2);
   c_capture: cover property (st.state == dec_pkg::state_running && rst_hit && count_out != 0);
endmodule // dec_unit
